// File: rtl/sarrt_top.sv
// Strobed register access was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module sarrt_top (
  // Clock and reset.
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // Register port.
  input  wire sarrt_pkg::sarrt_bus_req_t bus_req,
  output logic [7:0]                    bus_rdata,
  // Analog core.
  input  wire logic                     comp_ge,
  output var sarrt_pkg::sarrt_analog_t  ana_ctrl,
  // Interrupt.
  output logic                          irq
);
  import sarrt_pkg::*;

  sarrt_top_state_t st_reg;
  sarrt_top_state_t st_next;
  logic             adc_tick;
  logic             comp_sync;
  logic             busy;
  logic             period_end;
  logic [3:0]       lsb_idx;
  logic [3:0]       idx_dn;
  logic [7:0]       rd_mux;

  assign busy       = (st_reg.fsm == ST_SAMPLE) || (st_reg.fsm == ST_CONVERT);
  assign period_end = adc_tick && (st_reg.quarter == QUARTER_LAST);
  assign lsb_idx    = st_reg.conv12 ? LSB_INDEX_12 : LSB_INDEX_8;
  assign idx_dn     = 4'(st_reg.bit_idx - 4'h1);

  // Converter clock is an enable pulse, live only while converting.
  sarrt_clkdiv u_clkdiv (
    .clk      (clk),
    .nrst     (nrst),
    .run      (busy),
    .sel      (st_reg.clk_sel),
    .adc_tick (adc_tick)
  );

  // Comparator decision arrives from the analog core asynchronously.
  sarrt_sync u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in (comp_ge),
    .sync_out (comp_sync)
  );

  // Read multiplexer; reserved bits and unmapped addresses read zero.
  always_comb begin
    rd_mux = 8'h00;
    case (bus_req.addr)
      ADDR_REF_SEL: begin
        rd_mux[POS_EXT_REF]              = st_reg.ext_ref;
        rd_mux[POS_REF_LEVEL+1:POS_REF_LEVEL] = st_reg.ref_level;
      end
      ADDR_RES_HIGH: begin
        rd_mux = st_reg.res_hi;
      end
      ADDR_CLK_RES: begin
        rd_mux[POS_CLK_SEL_HI] = st_reg.clk_sel[1];
        rd_mux[POS_RES_SEL]    = st_reg.res12;
        rd_mux[POS_CLK_SEL_LO] = st_reg.clk_sel[0];
        rd_mux[3:0]            = st_reg.res_lo;
      end
      ADDR_CTRL: begin
        rd_mux[POS_START] = st_reg.start;
        rd_mux[POS_EOC]   = st_reg.eoc;
      end
      ADDR_IRQ_STAT: begin
        rd_mux[POS_IRQ_DONE] = st_reg.irq_stat;
      end
      ADDR_IRQ_MASK: begin
        rd_mux[POS_IRQ_DONE] = st_reg.irq_mask;
      end
      default: begin
        rd_mux = 8'h00;
      end
    endcase
  end

  // Next state: software writes first, so hardware events later in the block win.
  always_comb begin
    st_next       = st_reg;
    st_next.rdata = 8'h00;
    if (bus_req.rd) begin
      st_next.rdata = rd_mux;
    end
    if (bus_req.wr) begin
      case (bus_req.addr)
        ADDR_REF_SEL: begin
          st_next.ext_ref   = bus_req.wdata[POS_EXT_REF];
          st_next.ref_level = bus_req.wdata[POS_REF_LEVEL+1:POS_REF_LEVEL];
        end
        ADDR_CLK_RES: begin
          // Result nibble bits are read-only and dropped here.
          st_next.clk_sel = {bus_req.wdata[POS_CLK_SEL_HI], bus_req.wdata[POS_CLK_SEL_LO]};
          st_next.res12   = bus_req.wdata[POS_RES_SEL];
        end
        ADDR_CTRL: begin
          if (!bus_req.wdata[POS_EOC]) begin
            st_next.eoc = 1'b0;
          end
          // A start while busy is ignored; the running conversion is not disturbed.
          if (bus_req.wdata[POS_START] && (st_reg.fsm == ST_IDLE)) begin
            st_next.start   = 1'b1;
            st_next.eoc     = 1'b0;
            st_next.conv12  = st_reg.res12;
            st_next.fsm     = ST_SAMPLE;
            st_next.quarter = 2'h0;
            st_next.period  = 5'h00;
            st_next.sar     = 12'h000;
          end
        end
        ADDR_IRQ_STAT: begin
          if (bus_req.wdata[POS_IRQ_DONE]) begin
            st_next.irq_stat = 1'b0;
          end
        end
        ADDR_IRQ_MASK: begin
          st_next.irq_mask = bus_req.wdata[POS_IRQ_DONE];
        end
        default: begin
          st_next.irq_mask = st_next.irq_mask;
        end
      endcase
    end
    if (busy && adc_tick) begin
      st_next.quarter = 2'(st_reg.quarter + 2'h1);
    end
    case (st_reg.fsm)
      ST_IDLE: begin
        st_next.fsm = st_next.fsm;
      end
      ST_SAMPLE: begin
        if (period_end) begin
          st_next.period = 5'(st_reg.period + 5'h01);
          if (st_reg.period == 5'(SAMPLE_PERIODS - 5'h01)) begin
            st_next.fsm     = ST_CONVERT;
            st_next.bit_idx = MSB_INDEX;
            st_next.sar     = 12'h800;
          end
        end
      end
      ST_CONVERT: begin
        // One bit decided per period; 12 or 8 decisions after the sampling periods.
        if (period_end) begin
          if (!comp_sync) begin
            st_next.sar[st_reg.bit_idx] = 1'b0;
          end
          if (st_reg.bit_idx == lsb_idx) begin
            st_next.fsm = ST_DONE;
          end else begin
            st_next.bit_idx      = idx_dn;
            st_next.sar[idx_dn]  = 1'b1;
          end
        end
      end
      ST_DONE: begin
        // The buffer is loaded only here, so reads mid-conversion see the old result.
        st_next.res_hi   = st_reg.sar[11:4];
        st_next.res_lo   = st_reg.conv12 ? st_reg.sar[3:0] : 4'h0;
        st_next.eoc      = 1'b1;
        st_next.irq_stat = 1'b1;
        st_next.start    = 1'b0;
        st_next.fsm      = ST_IDLE;
      end
      default: begin
        st_next.fsm = ST_IDLE;
      end
    endcase
  end

  // State register; the result buffer is cleared only to keep simulation defined.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg           <= '0;
      st_reg.fsm       <= ST_IDLE;
      st_reg.ext_ref   <= RST_EXT_REF;
      st_reg.ref_level <= RST_REF_LEVEL;
      st_reg.clk_sel   <= RST_CLK_SEL;
      st_reg.res12     <= RST_RES_SEL;
      st_reg.irq_mask  <= RST_IRQ_MASK;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs to the analog core and to software.
  assign ana_ctrl.sample      = (st_reg.fsm == ST_SAMPLE);
  assign ana_ctrl.dac_code    = st_reg.sar;
  assign ana_ctrl.ext_ref     = st_reg.ext_ref;
  assign ana_ctrl.ref_level   = st_reg.ref_level;
  assign ana_ctrl.analog_input_zero_as_ref = st_reg.ext_ref;
  assign bus_rdata            = st_reg.rdata;
  assign irq                  = st_reg.irq_stat && st_reg.irq_mask;

  // Helper logic for the checks below.
  logic [6:0] tick_cnt;
  logic [4:0] gap;
  logic       gap_valid;
  logic [1:0] sel_seen;
  logic       all_ge;
  logic       all_lt;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt  <= 7'h00;
      gap       <= 5'h00;
      gap_valid <= 1'b0;
      sel_seen  <= 2'h0;
      all_ge    <= 1'b0;
      all_lt    <= 1'b0;
    end else begin
      sel_seen <= st_reg.clk_sel;
      if (st_reg.fsm == ST_IDLE) begin
        tick_cnt <= 7'h00;
        all_ge   <= 1'b1;
        all_lt   <= 1'b1;
      end else if (adc_tick) begin
        tick_cnt <= 7'(tick_cnt + 7'h01);
      end
      if ((st_reg.fsm == ST_CONVERT) && period_end) begin
        all_ge <= all_ge && comp_sync;
        all_lt <= all_lt && !comp_sync;
      end
      gap <= adc_tick ? 5'h01 : 5'(gap + 5'h01);
      if (!busy || (sel_seen != st_reg.clk_sel)) begin
        gap_valid <= 1'b0;
      end else if (adc_tick) begin
        gap_valid <= 1'b1;
      end
    end
  end

  sequence s_start_write;
    bus_req.wr && (bus_req.addr == ADDR_CTRL) && bus_req.wdata[POS_START]
      && (st_reg.fsm == ST_IDLE);
  endsequence

  sequence s_finish;
    st_reg.fsm == ST_DONE;
  endsequence

  sequence s_sample_end;
    (st_reg.fsm == ST_SAMPLE) && period_end
      && (st_reg.period == 5'(SAMPLE_PERIODS - 5'h01));
  endsequence

  a_start_clears_eoc: assert property (@(posedge clk) disable iff (!nrst)
    s_start_write |=> (!st_reg.eoc && st_reg.start && st_reg.fsm == ST_SAMPLE))
    else $error("start did not clear end flag");

  a_done_sets_flags: assert property (@(posedge clk) disable iff (!nrst)
    s_finish |=> (st_reg.eoc && !st_reg.start && st_reg.irq_stat && st_reg.fsm == ST_IDLE))
    else $error("completion flags wrong");

  a_conv_length_ok: assert property (@(posedge clk) disable iff (!nrst)
    s_finish |-> (tick_cnt == (st_reg.conv12 ? TICKS_12BIT : TICKS_8BIT)))
    else $error("conversion length wrong");

  a_div_ratio_ok: assert property (@(posedge clk) disable iff (!nrst)
    (adc_tick && gap_valid && sel_seen == st_reg.clk_sel)
      |-> (gap == sarrt_div_ratio(st_reg.clk_sel)))
    else $error("converter clock ratio wrong");

  a_result_held: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.fsm != ST_DONE) |=> ($stable(st_reg.res_hi) && $stable(st_reg.res_lo)))
    else $error("result changed outside completion");

  a_result_split12: assert property (@(posedge clk) disable iff (!nrst)
    (s_finish and st_reg.conv12) |=> ({st_reg.res_hi, st_reg.res_lo} == $past(st_reg.sar)))
    else $error("twelve-bit result split wrong");

  a_result_8bit: assert property (@(posedge clk) disable iff (!nrst)
    (s_finish and !st_reg.conv12)
      |=> (st_reg.res_hi == $past(st_reg.sar[11:4]) && st_reg.res_lo == 4'h0))
    else $error("eight-bit result placement wrong");

  a_saturate_ends: assert property (@(posedge clk) disable iff (!nrst)
    s_finish |-> ((!all_ge || st_reg.sar[11:4] == 8'hFF)
      && (!all_lt || st_reg.sar == 12'h000)))
    else $error("result not saturated");

  a_ref_routing: assert property (@(posedge clk) disable iff (!nrst)
    (bus_req.wr && bus_req.addr == ADDR_REF_SEL)
      |=> (ana_ctrl.analog_input_zero_as_ref == $past(bus_req.wdata[POS_EXT_REF])
      && ana_ctrl.ref_level == $past(bus_req.wdata[POS_REF_LEVEL+1:POS_REF_LEVEL])
      && ana_ctrl.ext_ref == ana_ctrl.analog_input_zero_as_ref))
    else $error("reference routing wrong");

  a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.fsm == ST_DONE && st_reg.irq_mask) |=> irq [*2])
    else $error("interrupt not raised");

  // Read data are zero outside the cycle after a read strobe, so a stale byte is never seen.
  a_rdata_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !bus_req.rd |=> (bus_rdata == 8'h00))
    else $error("read data outside read cycle");

  // A result read returns the buffer as it stood when the strobe was taken.
  a_rdata_result: assert property (@(posedge clk) disable iff (!nrst)
    (bus_req.rd && bus_req.addr == ADDR_RES_HIGH)
      |=> (bus_rdata == $past(st_reg.res_hi)))
    else $error("result read wrong");

  // Software writes to either result location leave the buffer alone.
  a_result_wr_ignored: assert property (@(posedge clk) disable iff (!nrst)
    (bus_req.wr && (bus_req.addr == ADDR_RES_HIGH || bus_req.addr == ADDR_CLK_RES)
      && st_reg.fsm != ST_DONE) |=> ($stable(st_reg.res_hi) && $stable(st_reg.res_lo)))
    else $error("result buffer took a write");

  // The resolution in use is frozen at start; a mid-run change waits for the next start.
  a_res_latched: assert property (@(posedge clk) disable iff (!nrst)
    busy |=> $stable(st_reg.conv12))
    else $error("resolution changed mid conversion");

  // The first trial after sampling sets only the most significant bit.
  a_first_trial_msb: assert property (@(posedge clk) disable iff (!nrst)
    s_sample_end |=> (st_reg.fsm == ST_CONVERT && ana_ctrl.dac_code == 12'h800))
    else $error("first trial code wrong");

  // The end flag has a single source: the completion cycle.
  a_eoc_only_done: assert property (@(posedge clk) disable iff (!nrst)
    $rose(st_reg.eoc) |-> ($past(st_reg.fsm) == ST_DONE))
    else $error("end flag rose early");

  // Start reads back set for the whole run, even if software writes a zero to it.
  a_start_while_busy: assert property (@(posedge clk) disable iff (!nrst)
    busy |-> st_reg.start)
    else $error("start bit dropped mid conversion");

  // The converter clock is quiet while idle, which keeps each run aligned to its start.
  a_idle_no_tick: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.fsm == ST_IDLE) |=> !adc_tick)
    else $error("converter clock ran while idle");

  // Each trial code is held for a full period, so the comparator has time to settle.
  a_trial_steady: assert property (@(posedge clk) disable iff (!nrst)
    (st_reg.fsm == ST_CONVERT && !period_end) |=> $stable(ana_ctrl.dac_code))
    else $error("trial code changed inside a period");

endmodule : sarrt_top
`default_nettype wire

// File: rtl/sarrt_pkg.sv
// Notes on behaviour
// - Result is twelve bits, split high/low.
// - Result buffer ignores writes; reset value undefined.
// - Eight-bit mode: whole result in high byte.
// - Twelve-bit mode: high byte plus low nibble.
// - Result is straight unsigned binary of input.
// - Out-of-range input saturates to full or zero.
// - External bit set selects pin as reference.
// - Otherwise level field picks internal reference.
// - Shared pin is port/input zero unless external.
// - Conversion runs from start until end flag.
// - Twelve-bit conversion takes 64 converter clocks.
// - Eight-bit conversion takes 48 converter clocks.
// - Divider select: 16, 8, 1, 2.
// - Start bit clears itself at conversion end.
// - Completion sets end flag, interrupt flag, result.
package sarrt_pkg;

  // Register addresses on the plain register port.
  localparam logic [7:0] ADDR_REF_SEL   = 8'hAF;
  localparam logic [7:0] ADDR_RES_HIGH  = 8'hB2;
  localparam logic [7:0] ADDR_CLK_RES   = 8'hB3;
  localparam logic [7:0] ADDR_CTRL      = 8'hB4;
  localparam logic [7:0] ADDR_IRQ_STAT  = 8'hB5;
  localparam logic [7:0] ADDR_IRQ_MASK  = 8'hB6;

  // Field positions.
  localparam int POS_EXT_REF    = 7;
  localparam int POS_REF_LEVEL  = 0;
  localparam int POS_CLK_SEL_HI = 6;
  localparam int POS_RES_SEL    = 5;
  localparam int POS_CLK_SEL_LO = 4;
  localparam int POS_START      = 6;
  localparam int POS_EOC        = 5;
  localparam int POS_IRQ_DONE   = 0;

  // Reset values.
  localparam logic       RST_EXT_REF   = 1'b0;
  localparam logic [1:0] RST_REF_LEVEL = 2'h0;
  localparam logic [1:0] RST_CLK_SEL   = 2'h0;
  localparam logic       RST_RES_SEL   = 1'b0;
  localparam logic       RST_IRQ_MASK  = 1'b0;

  // Timing: one period is four converter clocks; sampling takes four periods.
  localparam logic [1:0] QUARTER_LAST   = 2'h3;
  localparam logic [4:0] SAMPLE_PERIODS = 5'h04;
  localparam logic [6:0] TICKS_12BIT    = 7'h40;
  localparam logic [6:0] TICKS_8BIT     = 7'h30;
  localparam logic [3:0] MSB_INDEX      = 4'hB;
  localparam logic [3:0] LSB_INDEX_12   = 4'h0;
  localparam logic [3:0] LSB_INDEX_8    = 4'h4;

  // Divider select codes.
  localparam logic [1:0] DIV_SEL_16 = 2'h0;
  localparam logic [1:0] DIV_SEL_8  = 2'h1;
  localparam logic [1:0] DIV_SEL_1  = 2'h2;
  localparam logic [1:0] DIV_SEL_2  = 2'h3;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h1,
    ST_SAMPLE  = 4'h2,
    ST_CONVERT = 4'h4,
    ST_DONE    = 4'h8
  } sarrt_fsm_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } sarrt_bus_req_t;

  typedef struct packed {
    logic        sample;
    logic [11:0] dac_code;
    logic        ext_ref;
    logic [1:0]  ref_level;
    logic        analog_input_zero_as_ref;
  } sarrt_analog_t;

  typedef struct packed {
    sarrt_fsm_t  fsm;
    logic        start;
    logic        eoc;
    logic        res12;
    logic        conv12;
    logic [1:0]  clk_sel;
    logic        ext_ref;
    logic [1:0]  ref_level;
    logic        irq_stat;
    logic        irq_mask;
    logic [7:0]  res_hi;
    logic [3:0]  res_lo;
    logic [11:0] sar;
    logic [3:0]  bit_idx;
    logic [1:0]  quarter;
    logic [4:0]  period;
    logic [7:0]  rdata;
  } sarrt_top_state_t;

  typedef struct packed {
    logic [4:0] cnt;
    logic       tick;
  } sarrt_div_state_t;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sarrt_sync_state_t;

  // Division ratio of the converter clock for each select code.
  function automatic logic [4:0] sarrt_div_ratio(input logic [1:0] sel);
    logic [4:0] r;
    r = 5'h10;
    case (sel)
      DIV_SEL_16: r = 5'h10;
      DIV_SEL_8:  r = 5'h08;
      DIV_SEL_1:  r = 5'h01;
      DIV_SEL_2:  r = 5'h02;
      default:    r = 5'h10;
    endcase
    return r;
  endfunction : sarrt_div_ratio

endpackage : sarrt_pkg

// File: rtl/sarrt_clkdiv.sv
`timescale 1ns/1ps
`default_nettype none
module sarrt_clkdiv (
  // Clock and reset.
  input  wire logic       clk,
  input  wire logic       nrst,
  // Control.
  input  wire logic       run,
  input  wire logic [1:0] sel,
  // Converter clock enable.
  output logic            adc_tick
);
  import sarrt_pkg::*;

  sarrt_div_state_t st_reg;
  sarrt_div_state_t st_next;

  // Counter restarts whenever the converter idles, so every conversion starts aligned.
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (!run) begin
      st_next.cnt = 5'h00;
    end else if (st_reg.cnt >= 5'(sarrt_div_ratio(sel) - 5'h01)) begin
      st_next.cnt  = 5'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = 5'(st_reg.cnt + 5'h01);
    end
  end

  // State register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign adc_tick = st_reg.tick;

endmodule : sarrt_clkdiv
`default_nettype wire

// File: rtl/sarrt_sync.sv
`timescale 1ns/1ps
`default_nettype none
module sarrt_sync (
  // Clock and reset.
  input  wire logic clk,
  input  wire logic nrst,
  // Asynchronous level and its filtered copy.
  input  wire logic async_in,
  output logic      sync_out
);
  import sarrt_pkg::*;

  sarrt_sync_state_t st_reg;
  sarrt_sync_state_t st_next;
  logic              agreed;

  // A change counts only once the second and third stages agree.
  always_comb begin
    agreed     = (st_reg.s2 == st_reg.s3) ? st_reg.s3 : st_reg.q;
    st_next    = st_reg;
    st_next.s1 = async_in;
    st_next.s2 = st_reg.s1;
    st_next.s3 = st_reg.s2;
    st_next.q  = agreed;
  end

  // State register.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sync_out = agreed;

endmodule : sarrt_sync
`default_nettype wire

// File: test/test_sar_adc_result_ref_timing.sv
`timescale 1ns/1ps
`default_nettype none
module test_sar_adc_result_ref_timing;
  import sarrt_pkg::*;

  // Bench signals.
  logic           clk;
  logic           nrst;
  sarrt_bus_req_t bus_req;
  logic [7:0]     bus_rdata;
  logic           comp_ge;
  sarrt_analog_t  ana_ctrl;
  logic           irq;
  logic [11:0]    vin;
  logic [7:0]     rdv;
  logic [11:0]    prev;
  logic [7:0]     probe [6];
  int             fail_count;
  int             total_checks;

  sarrt_top sarrt_top_i (
    .clk       (clk),
    .nrst      (nrst),
    .bus_req   (bus_req),
    .bus_rdata (bus_rdata),
    .comp_ge   (comp_ge),
    .ana_ctrl  (ana_ctrl),
    .irq       (irq)
  );

  // Ideal comparator; the input is held still, so it settles at once.
  always_comb begin
    comp_ge = (vin >= ana_ctrl.dac_code);
  end

  // Clock of 5 ns period.
  always #2.5 clk = ~clk;

  // Compare and count.
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // One write cycle, then the bus goes idle.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b0, rd: 1'b0};
  endtask : wr

  // One read cycle; the data stand only in the following cycle.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
    #1;
    rdv = bus_rdata;
    check({4'h0, rdv}, {4'h0, e});
  endtask : rd_chk

  // Let an edge pass so registered outputs have landed.
  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  // Configure, start, probe mid-run, then time and check the result.
  task automatic conv(input logic [1:0] sel, input logic res, input logic [11:0] v,
                      input logic first);
    logic [11:0] e;
    logic [7:0]  hi;
    int          n;
    int          lim;
    int          cyc;
    int          i;
    realtime     t0;
    e = res ? v : {v[11:4], 4'h0};
    n = (sel == 2'h0) ? 16 : (sel == 2'h1) ? 8 : (sel == 2'h2) ? 1 : 2;
    lim = (res ? 64 : 48) * n + 2;
    vin <= v;
    wr(ADDR_CLK_RES, {1'b0, sel[1], res, sel[0], 4'hF});
    wr(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h01);
    wr(ADDR_CTRL, 8'h40);
    t0 = $realtime;
    settle();
    check({11'h0, ana_ctrl.sample}, 12'h001);
    if (!first) begin
      rd_chk(ADDR_RES_HIGH, prev[11:4]);
    end
    rd_chk(ADDR_CTRL, 8'h40);
    wr(ADDR_RES_HIGH, 8'h5A);
    wr(ADDR_CLK_RES, {1'b0, sel[1], res, sel[0], 4'h5});
    if (!first) begin
      rd_chk(ADDR_RES_HIGH, prev[11:4]);
      rd_chk(ADDR_CLK_RES, {1'b0, sel[1], res, sel[0], prev[3:0]});
    end
    for (i = 0; i < 3000 && irq !== 1'b1; i++) begin
      settle();
    end
    // Real time keeps the half-nanosecond clock phase out of the cycle count.
    cyc = int'(($realtime - t0 - 1.0) / 5.0);
    check({11'h0, (cyc >= lim - 2 && cyc <= lim + 2)}, 12'h001);
    rd_chk(ADDR_RES_HIGH, e[11:4]);
    hi = rdv;
    rd_chk(ADDR_CLK_RES, {1'b0, sel[1], res, sel[0], e[3:0]});
    if (res) begin
      check({2'h0, hi, rdv[3:2]}, {2'h0, v[11:2]});
    end
    rd_chk(ADDR_CTRL, 8'h20);
    check({11'h0, irq}, 12'h001);
    // Writes after completion must not disturb the fresh result either.
    wr(ADDR_RES_HIGH, 8'h5A);
    wr(ADDR_CLK_RES, {1'b0, sel[1], res, sel[0], 4'h5});
    rd_chk(ADDR_RES_HIGH, e[11:4]);
    rd_chk(ADDR_CLK_RES, {1'b0, sel[1], res, sel[0], e[3:0]});
    prev = e;
    $display("test conversion sel=%h res=%h done", sel, res);
  endtask : conv

  // Print the counts and the verdict, then stop.
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : conclude

  // Watchdog well beyond the fewer than two thousand cycles the tests need.
  initial begin
    #100000;
    fail_count++;
    conclude();
  end

  // Main sequence.
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    bus_req = '0;
    vin = 12'h000;
    prev = 12'h000;
    fail_count = 0;
    total_checks = 0;
    probe = '{ADDR_REF_SEL, ADDR_CLK_RES, ADDR_CTRL, ADDR_IRQ_STAT, ADDR_IRQ_MASK, 8'h00};
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    // Reset values; the result nibble resets to zero by the designer's choice.
    for (int k = 0; k < 6; k++) begin
      rd_chk(probe[k], 8'h00);
    end
    settle();
    check({4'h0, bus_rdata}, 12'h000);
    check({11'h0, irq}, 12'h000);
    wr(8'h00, 8'hFF);
    rd_chk(8'h00, 8'h00);
    $display("test reset done");
    // Every internal level, then the external reference.
    for (int l = 0; l < 4; l++) begin
      wr(ADDR_REF_SEL, 8'(l));
      rd_chk(ADDR_REF_SEL, 8'(l));
      check({8'h0, ana_ctrl.ext_ref, ana_ctrl.analog_input_zero_as_ref, ana_ctrl.ref_level},
            12'(l));
    end
    wr(ADDR_REF_SEL, 8'h82);
    rd_chk(ADDR_REF_SEL, 8'h82);
    check({8'h0, ana_ctrl.ext_ref, ana_ctrl.analog_input_zero_as_ref, ana_ctrl.ref_level},
          12'h00E);
    wr(ADDR_REF_SEL, 8'h00);
    $display("test reference done");
    // Every divider code, both resolutions, both saturation ends.
    conv(2'h3, 1'b1, 12'hA5C, 1'b1);
    conv(2'h1, 1'b0, 12'h3B7, 1'b0);
    conv(2'h2, 1'b1, 12'hFFF, 1'b0);
    conv(2'h0, 1'b0, 12'hFFF, 1'b0);
    conv(2'h3, 1'b1, 12'h000, 1'b0);
    // Mask, unmask and clear the done interrupt.
    wr(ADDR_IRQ_MASK, 8'h00);
    settle();
    check({11'h0, irq}, 12'h000);
    rd_chk(ADDR_IRQ_STAT, 8'h01);
    wr(ADDR_IRQ_MASK, 8'h01);
    settle();
    check({11'h0, irq}, 12'h001);
    wr(ADDR_IRQ_STAT, 8'h01);
    settle();
    check({11'h0, irq}, 12'h000);
    rd_chk(ADDR_IRQ_STAT, 8'h00);
    $display("test interrupt done");
    conclude();
  end
endmodule : test_sar_adc_result_ref_timing
`default_nettype wire
